// *** common/rwu_defs.svh ***
/*
 * constants of the reset and watchdog unit: register offsets, field
 * positions, reset values, cycle lengths and selector codes.
 * assumes inclusion by bare name from the unit's package and design file.
 */
`ifndef RWU_DEFS_SVH
`define RWU_DEFS_SVH

`define RWU_ADDR_W 8
`define RWU_OFF_CTRL 8'h00
`define RWU_OFF_STATUS 8'h04
`define RWU_OFF_FIRST_CFG 8'h08
`define RWU_NUM_CFG 6
`define RWU_IDX_START 3'h0
`define RWU_IDX_WAKEREQ 3'h1
`define RWU_IDX_WAKEEN 3'h2
`define RWU_IDX_IRQEN 3'h3
`define RWU_IDX_PORT 3'h4
`define RWU_IDX_CLK 3'h5
`define RWU_IDX_NONE 3'h7
`define RWU_SYNC_IDLE 10'h0ff

`define RWU_CTRL_KICK 0
`define RWU_FLAG_W 7
`define RWU_DIR_IN 12'h000
`define RWU_PULL_ON 4'hf
`define RWU_ALARM_LOW 1'b0
`define RWU_SRC_BASE 2'h0
`define RWU_SRC_TAP8 2'h2
`define RWU_DUTY_1_4 2'h0
`define RWU_DUTY_3_4 2'h1
`define RWU_CLK_SLOW 1'b0
`define RWU_PC_START 12'h000
`define RWU_ZERO32 32'h0000_0000

`define RWU_CYC_LONG 15'h4000
`define RWU_CYC_SHORT 15'h0800
`define RWU_WD_LIM_8 9'h007
`define RWU_WD_LIM_64 9'h03f
`define RWU_WD_LIM_512 9'h1ff

`define RWU_CAUSE_POR 0
`define RWU_CAUSE_PIN 1
`define RWU_CAUSE_KEY 2
`define RWU_CAUSE_WD 3

`endif

// *** common/rwu_pkg.sv ***
/*
 * types of the reset and watchdog unit: register layouts and states.
 * assumes rwu_defs.svh sits beside it on the include path.
 */
`include "rwu_defs.svh"

package rwu_pkg;

	typedef struct packed {
		logic [13:0] rsvd;
		logic backupDriveFlag;
		logic alarmOut;
		logic [3:0] keyPortPullDown;
		logic [11:0] portDir;
	} rwu_port_t;

	typedef struct packed {
		logic [11:0] rsvd;
		logic coreClkSel;
		logic [1:0] timerActive;
		logic [2:0] converterDrivePins;
		logic converterActive;
		logic freqGenEnable;
		logic [1:0] freqGenDuty;
		logic [1:0] freqGenSrc;
		logic [1:0] clearClkDuty;
		logic [1:0] clearClkSrc;
		logic [1:0] pumpClkDuty;
		logic [1:0] pumpClkSrc;
	} rwu_clk_t;

	typedef struct packed {
		logic [6:0] startConditionFlag;
		logic [6:0] wakeRequestFlag;
		logic [6:0] wakeEnableFlag;
		logic [6:0] irqEnableFlag;
	} rwu_flags_t;

	typedef struct packed {
		logic keyPortActive;
		logic matrixActive;
		logic scanPulse;
		logic baseTick;
		logic tapTenTick;
		logic coreSleep;
	} rwu_core_t;

	typedef enum logic [2:0] {
		RWU_RUN = 3'b001,
		RWU_HOLD = 3'b010,
		RWU_COUNT = 3'b100
	} rwu_state_t;

endpackage

// *** design/rwu_reset_watchdog.sv ***
/*
 * reset generation and watchdog unit with an apb register slave.
 * assumes base and tap-ten ticks, scan pulse and sleep state come from
 * logic on clk; reset pin, power-on detect and key pins are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rwu_defs.svh"

module rwu_reset_watchdog #(
	parameter bit LONG_CYCLE = 1'b1,
	parameter bit POR_USE = 1'b1,
	parameter logic [3:0] KEY_USE = 4'hf,
	parameter logic [1:0] WD_SEL = 2'h2,
	parameter bit LCD_ALL_ON = 1'b1,
	parameter bit BATTERY = 1'b1,
	parameter logic [14:0] CYCLE_LEN =
		LONG_CYCLE ? `RWU_CYC_LONG : `RWU_CYC_SHORT
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`RWU_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// asynchronous reset sources
	input wire logic powerOnDetect,
	input wire logic resetPin,
	input wire logic [3:0] keyInputPort,
	input wire logic [3:0] matrixReturnInput,
	// core timing and status
	input wire rwu_pkg::rwu_core_t core,
	// reset outputs
	output logic systemReset,
	output logic prescalerLowReset,
	output logic [11:0] programCounterInit,
	output logic segAllOn,
	output logic segAllOff,
	// watchdog and held state
	output logic watchdogActiveFlag,
	output rwu_pkg::rwu_flags_t flags,
	output rwu_pkg::rwu_port_t portCfg,
	output rwu_pkg::rwu_clk_t clkCfg
);
	import rwu_pkg::*;

	function automatic logic [2:0] cfgIndex(input logic [7:0] a);
		logic [7:0] rel;
		rel = a - `RWU_OFF_FIRST_CFG;
		if (a < `RWU_OFF_FIRST_CFG || rel[1:0] != 2'h0 ||
		    rel[7:2] >= 6'(`RWU_NUM_CFG)) begin
			cfgIndex = `RWU_IDX_NONE;
		end else begin
			cfgIndex = rel[4:2];
		end
	endfunction

	function automatic logic [31:0] initVal(input logic [2:0] i);
		rwu_port_t p;
		rwu_clk_t c;
		p = '0;
		c = '0;
		p.portDir = `RWU_DIR_IN;
		p.keyPortPullDown = `RWU_PULL_ON;
		p.alarmOut = `RWU_ALARM_LOW;
		p.backupDriveFlag = BATTERY;
		c.pumpClkSrc = `RWU_SRC_BASE;
		c.pumpClkDuty = `RWU_DUTY_3_4;
		c.clearClkSrc = `RWU_SRC_TAP8;
		c.clearClkDuty = `RWU_DUTY_1_4;
		c.freqGenSrc = `RWU_SRC_BASE;
		c.freqGenDuty = `RWU_DUTY_1_4;
		c.freqGenEnable = 1'b0;
		c.converterActive = 1'b0;
		c.converterDrivePins = 3'h0;
		c.timerActive = 2'h0;
		c.coreClkSel = `RWU_CLK_SLOW;
		if (i == `RWU_IDX_PORT) begin
			initVal = p;
		end else if (i == `RWU_IDX_CLK) begin
			initVal = c;
		end else begin
			initVal = `RWU_ZERO32;
		end
	endfunction

	// two-flop synchronisers for every pin input
	logic [9:0] pinMeta_ff;
	logic [9:0] pinSync_ff;
	logic porSync;
	logic pinSync;
	logic [3:0] keySync;
	logic [3:0] matSync;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			// key pins rest high: no false all-zero request after reset
			pinMeta_ff <= `RWU_SYNC_IDLE;
			pinSync_ff <= `RWU_SYNC_IDLE;
		end else if (ce) begin
			pinMeta_ff <= {powerOnDetect, resetPin, keyInputPort,
				matrixReturnInput};
			pinSync_ff <= pinMeta_ff;
		end
	end

	assign porSync = pinSync_ff[9];
	assign pinSync = pinSync_ff[8];
	assign keySync = pinSync_ff[7:4];
	assign matSync = pinSync_ff[3:0];

	// key reset detection
	logic keyPortReq;
	logic matrixAllZero;
	logic matrixPend_ff;
	logic nxt_matrixPend;
	logic matrixReq;

	assign keyPortReq = core.keyPortActive && (KEY_USE != 4'h0) &&
		((keySync & KEY_USE) == 4'h0);
	assign matrixAllZero = core.matrixActive && (KEY_USE != 4'h0) &&
		((matSync & KEY_USE) == 4'h0);
	assign matrixReq = matrixPend_ff && core.scanPulse;

	always_comb begin
		nxt_matrixPend = matrixPend_ff;
		if (matrixReq) begin
			nxt_matrixPend = 1'b0;
		end
		if (matrixAllZero) begin
			nxt_matrixPend = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			matrixPend_ff <= 1'b0;
		end else if (ce) begin
			matrixPend_ff <= nxt_matrixPend;
		end
	end

	// watchdog counter
	logic [8:0] wdCount_ff;
	logic [8:0] wdLimit;
	logic wdOverflow;
	logic wdKick;
	logic otherReq;
	logic anyReq;

	always_comb begin
		unique case (WD_SEL)
			2'h0: wdLimit = `RWU_WD_LIM_8;
			2'h1: wdLimit = `RWU_WD_LIM_64;
			default: wdLimit = `RWU_WD_LIM_512;
		endcase
	end

	assign wdOverflow = watchdogActiveFlag && core.tapTenTick &&
		!core.coreSleep && !wdKick && (wdCount_ff == wdLimit);
	assign otherReq = (POR_USE && porSync) || pinSync || keyPortReq ||
		matrixReq;
	assign anyReq = otherReq || wdOverflow;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			wdCount_ff <= 9'h000;
			watchdogActiveFlag <= 1'b0;
		end else if (ce) begin
			if (otherReq || (systemReset && prescalerLowReset)) begin
				wdCount_ff <= 9'h000;
				watchdogActiveFlag <= 1'b0;
			end else if (wdKick) begin
				wdCount_ff <= 9'h000;
				watchdogActiveFlag <= 1'b1;
			end else if (wdOverflow) begin
				wdCount_ff <= 9'h000;
			end else if (watchdogActiveFlag && core.tapTenTick &&
			    !core.coreSleep) begin
				wdCount_ff <= wdCount_ff + 9'h001;
			end
		end
	end

	// reset cycle sequencer
	rwu_state_t state_ff;
	rwu_state_t nxt_state;
	logic [14:0] cycCount_ff;
	logic [14:0] nxt_cycCount;
	logic [3:0] cause_ff;
	logic cycleDone;

	// a zero count, as left by reset, also ends at the next tick
	assign cycleDone = core.baseTick && (cycCount_ff <= 15'h0001);

	always_comb begin
		nxt_state = state_ff;
		nxt_cycCount = cycCount_ff;
		unique case (state_ff)
			RWU_RUN: begin
				if (anyReq) begin
					nxt_state = RWU_COUNT;
					nxt_cycCount = CYCLE_LEN;
				end
			end
			RWU_HOLD: begin
				nxt_cycCount = CYCLE_LEN;
				if (!pinSync) begin
					nxt_state = RWU_COUNT;
				end
			end
			RWU_COUNT: begin
				if (anyReq) begin
					nxt_cycCount = CYCLE_LEN;
				end else if (cycleDone) begin
					nxt_state = RWU_RUN;
					nxt_cycCount = 15'h0000;
				end else if (core.baseTick) begin
					nxt_cycCount = cycCount_ff - 15'h0001;
				end
			end
		endcase
		if (pinSync) begin
			nxt_state = RWU_HOLD;
			nxt_cycCount = CYCLE_LEN;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_ff <= RWU_COUNT;
			cycCount_ff <= 15'h0000;
		end else if (ce) begin
			state_ff <= nxt_state;
			cycCount_ff <= nxt_cycCount;
		end
	end

	// system reset and segment outputs follow the next state so they leave flops
	always_ff @(posedge clk) begin
		if (!resetn) begin
			systemReset <= 1'b1;
			prescalerLowReset <= 1'b1;
			segAllOn <= LCD_ALL_ON;
			segAllOff <= !LCD_ALL_ON;
			programCounterInit <= `RWU_PC_START;
			cause_ff <= 4'h1;
		end else if (ce) begin
			systemReset <= (nxt_state != RWU_RUN);
			segAllOn <= (nxt_state != RWU_RUN) && LCD_ALL_ON;
			segAllOff <= (nxt_state != RWU_RUN) && !LCD_ALL_ON;
			programCounterInit <= `RWU_PC_START;
			if (otherReq) begin
				prescalerLowReset <= 1'b1;
			end else if (nxt_state == RWU_RUN) begin
				prescalerLowReset <= 1'b0;
			end
			if (anyReq) begin
				cause_ff <= {wdOverflow, keyPortReq || matrixReq, pinSync,
					POR_USE && porSync};
			end
		end
	end

	// apb slave: one wait state, write lands on the completing edge
	logic access;
	logic [2:0] idx;
	logic apbWrite;
	logic [31:0] cfgReg_ff [`RWU_NUM_CFG];
	logic [31:0] readMux;

	assign access = psel && penable;
	assign idx = cfgIndex(paddr);
	assign apbWrite = access && pready && pwrite && !pslverr;
	assign wdKick = apbWrite && (paddr == `RWU_OFF_CTRL) && !systemReset &&
		pwdata[`RWU_CTRL_KICK];

	generate
		for (genvar g = 0; g < `RWU_NUM_CFG; g++) begin : gCfg
			always_ff @(posedge clk) begin
				if (!resetn) begin
					cfgReg_ff[g] <= initVal(3'(g));
				end else if (ce) begin
					if (nxt_state != RWU_RUN) begin
						cfgReg_ff[g] <= initVal(3'(g));
					end else if (apbWrite && idx == 3'(g)) begin
						cfgReg_ff[g] <= pwdata & initMask(3'(g));
					end
				end
			end
		end
	endgenerate

	function automatic logic [31:0] initMask(input logic [2:0] i);
		if (i == `RWU_IDX_PORT) begin
			initMask = 32'h0003_ffff;
		end else if (i == `RWU_IDX_CLK) begin
			initMask = 32'h000f_ffff;
		end else begin
			initMask = 32'h0000_007f;
		end
	endfunction

	always_comb begin
		readMux = `RWU_ZERO32;
		if (paddr == `RWU_OFF_CTRL) begin
			readMux = {31'h0000_0000, watchdogActiveFlag};
		end else if (paddr == `RWU_OFF_STATUS) begin
			readMux = {12'h000, cause_ff, state_ff, systemReset,
				prescalerLowReset, matrixPend_ff, 1'b0, wdCount_ff};
		end else if (idx != `RWU_IDX_NONE) begin
			readMux = cfgReg_ff[idx];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `RWU_ZERO32;
		end else if (ce) begin
			pready <= access && !pready;
			pslverr <= access && !pready && idx == `RWU_IDX_NONE &&
				paddr != `RWU_OFF_CTRL && paddr != `RWU_OFF_STATUS;
			if (access && !pready && !pwrite) begin
				prdata <= readMux;
			end
		end
	end

	assign flags = {cfgReg_ff[`RWU_IDX_START][`RWU_FLAG_W-1:0],
		cfgReg_ff[`RWU_IDX_WAKEREQ][`RWU_FLAG_W-1:0],
		cfgReg_ff[`RWU_IDX_WAKEEN][`RWU_FLAG_W-1:0],
		cfgReg_ff[`RWU_IDX_IRQEN][`RWU_FLAG_W-1:0]};
	assign portCfg = cfgReg_ff[`RWU_IDX_PORT];
	assign clkCfg = cfgReg_ff[`RWU_IDX_CLK];

endmodule

`default_nettype wire

// *** verification/rwu_core_model.sv ***
/* core timing model: base, tap-ten and scan pulses plus sleep level.
   assumes one clock shared with the unit. */
`timescale 1ns/1ps
`default_nettype none
module rwu_core_model (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// firmware sleep request
	input wire logic sleep,
	// core timing
	output rwu_pkg::rwu_core_t core
);
	import rwu_pkg::*;
	logic [3:0] div_ff;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			div_ff <= 4'h0;
		end else begin
			div_ff <= div_ff + 4'h1;
		end
	end
	// base every 2, tap ten every 4, scan every 8 cycles
	assign core = '{1'b1, 1'b1, &div_ff[2:0], div_ff[0], &div_ff[1:0], sleep};
endmodule
`default_nettype wire

// *** verification/rwu_reset_monitor.sv ***
/* port checker of the reset and watchdog unit.
   assumes default build options: segments on, battery variant. */
`timescale 1ns/1ps
`default_nettype none
module rwu_reset_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// watched ports
	input wire logic resetPin,
	input wire logic systemReset,
	input wire logic prescalerLowReset,
	input wire logic [11:0] programCounterInit,
	input wire logic segAllOn,
	input wire logic segAllOff,
	input wire logic watchdogActiveFlag,
	input wire rwu_pkg::rwu_flags_t flags,
	input wire rwu_pkg::rwu_port_t portCfg,
	input wire rwu_pkg::rwu_clk_t clkCfg
);
	import rwu_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	chk_pc_zero:
		assert property (programCounterInit == 12'h000) else $error("pc");
	chk_flags_clear:
		assert property (systemReset |-> flags == '0) else $error("flags");
	chk_port_init:
		assert property (systemReset |-> portCfg == 32'h0002_f000)
		else $error("port");
	chk_clk_init:
		assert property (systemReset |-> clkCfg == 32'h0000_0024)
		else $error("clk");
	chk_seg_on:
		assert property (systemReset |-> segAllOn && !segAllOff)
		else $error("seg");
	chk_seg_idle:
		assert property (!systemReset |-> !segAllOn && !segAllOff)
		else $error("seg idle");
	chk_pin_hold:
		assert property (resetPin [*4] |-> systemReset) else $error("hold");
	chk_pin_release:
		assert property ($fell(resetPin) |-> systemReset [*3])
		else $error("release");
	chk_wd_stop:
		assert property (systemReset && prescalerLowReset |=>
			!watchdogActiveFlag) else $error("wd stop");
	chk_wd_keep:
		assert property (systemReset && !prescalerLowReset |->
			watchdogActiveFlag) else $error("wd keep");
endmodule
bind rwu_reset_watchdog rwu_reset_monitor mon (.clk, .resetn, .resetPin,
	.systemReset, .prescalerLowReset, .programCounterInit, .segAllOn,
	.segAllOff, .watchdogActiveFlag, .flags, .portCfg, .clkCfg);
`default_nettype wire

// *** verification/rwu_reset_watchdog_test.sv ***
/* self-checking bench of the reset and watchdog unit.
   assumes package, design, core model and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module rwu_reset_watchdog_test;
	import rwu_pkg::*;
	logic clk, resetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic powerOnDetect, resetPin, sleep, systemReset;
	logic prescalerLowReset, watchdogActiveFlag;
	logic [3:0] keyInputPort, matrixReturnInput;
	rwu_core_t core;
	int nFail = 0;
	int totalChecks = 0;
	int n;
	rwu_reset_watchdog #(.WD_SEL(2'h0), .CYCLE_LEN(15'h0010)) dut (.clk,
		.resetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .powerOnDetect, .resetPin,
		.keyInputPort, .matrixReturnInput, .core, .systemReset,
		.prescalerLowReset, .programCounterInit(), .segAllOn(),
		.segAllOff(), .watchdogActiveFlag, .flags(), .portCfg(), .clkCfg());
	rwu_core_model model (.clk, .resetn, .sleep, .core);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp) begin
			nFail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic waitRst(input logic v);
		int k;
		k = 0;
		while (systemReset !== v && k < 200) begin
			@(posedge clk);
			k++;
		end
		chk1(systemReset, v);
	endtask
	// counts ticks while the reset line keeps one level
	task automatic measure(input logic ten, input logic lvl);
		int k;
		n = 0;
		k = 0;
		while (systemReset === lvl && k < 300) begin
			n += int'(ten ? core.tapTenTick : core.baseTick);
			k++;
			@(posedge clk);
		end
	endtask
	task automatic results;
		$display("checks %0d failures %0d", totalChecks, nFail);
		if (nFail == 0 && totalChecks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (4000) @(posedge clk);
		nFail++;
		results();
	end
	initial begin
		{resetn, psel, penable, pwrite, powerOnDetect, resetPin, sleep} = '0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		keyInputPort = 4'hf;
		matrixReturnInput = 4'hf;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		waitRst(1'b0);
		apb(1'b0, 8'h1c, 32'h0000_0000);
		chk(rdat, 32'h0000_0024);
		apb(1'b0, 8'h18, 32'h0000_0000);
		chk(rdat, 32'h0002_f000);
		apb(1'b1, 8'h08, 32'h0000_007f);
		apb(1'b0, 8'h08, 32'h0000_0000);
		chk(rdat, 32'h0000_007f);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk1(rerr, 1'b1);
		$display("test init done");
		resetPin <= 1'b1;
		repeat (60) @(posedge clk);
		chk1(systemReset, 1'b1);
		resetPin <= 1'b0;
		repeat (3) @(posedge clk);
		measure(1'b0, 1'b1);
		chk1(n >= 14 && n <= 17, 1'b1);
		apb(1'b0, 8'h08, 32'h0000_0000);
		chk(rdat, 32'h0000_0000);
		$display("test pin done");
		for (int i = 0; i < 3; i++) begin
			if (i == 0) keyInputPort <= 4'h0;
			else if (i == 1) matrixReturnInput <= 4'h0;
			else powerOnDetect <= 1'b1;
			repeat (3) @(posedge clk);
			{keyInputPort, matrixReturnInput, powerOnDetect} <= 9'h1fe;
			waitRst(1'b1);
			waitRst(1'b0);
		end
		$display("test sources done");
		apb(1'b1, 8'h00, 32'h0000_0001);
		apb(1'b0, 8'h00, 32'h0000_0000);
		chk(rdat, 32'h0000_0001);
		repeat (4) begin
			repeat (12) @(posedge clk);
			apb(1'b1, 8'h00, 32'h0000_0001);
		end
		chk1(systemReset, 1'b0);
		sleep <= 1'b1;
		repeat (100) @(posedge clk);
		chk1(systemReset, 1'b0);
		sleep <= 1'b0;
		measure(1'b1, 1'b0);
		chk1(n >= 7 && n <= 9, 1'b1);
		chk1(prescalerLowReset, 1'b0);
		chk1(watchdogActiveFlag, 1'b1);
		apb(1'b0, 8'h04, 32'h0000_0000);
		chk(rdat & 32'h000f_0000, 32'h0008_0000);
		$display("test watchdog done");
		results();
	end
endmodule
`default_nettype wire
